/* File: rtl/rpbs_top.sv */
// Reset pin qualifier, pin pull-down and boot strap sampler
`timescale 1ns/1ns
`default_nettype none
`include "rpbs_map.svh"
module rpbs_top (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic         i_reset_pin,
    input  wire logic         i_internal_reset,
    input  wire logic         i_low_power,
    input  wire logic         i_program_strobe_strap,
    input  wire logic         i_external_fetch_select,
    output logic              o_reset_pin_out,
    output logic              o_reset_pin_oe,
    output logic              o_port_force_n,
    output logic              o_device_reset,
    output logic              o_wake,
    output logic              o_strap_oe,
    output var rpbs_pkg::rpbs_boot_t o_boot
);
    // ====================================================================
    // Pin synchronisers
    logic       pin_s1;
    logic       pin_s2;
    logic [1:0] fet_s;
    logic [6:0] low_cnt;
    logic       qualified;
    logic [3:0] pull_cnt;
    rpbs_pkg::rpbs_state_t state;
    logic       strap_s1;
    logic       strap_s2;
    logic       in_reset;

    // Two-flop synchronisers for pins
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pin_s1   <= 1'b1;
            pin_s2   <= 1'b1;
            strap_s1 <= 1'b1;
            strap_s2 <= 1'b1;
            fet_s    <= 2'b11;
        end else begin
            pin_s1   <= i_reset_pin;
            pin_s2   <= pin_s1;
            strap_s1 <= i_program_strobe_strap;
            strap_s2 <= strap_s1;
            fet_s    <= {fet_s[0], i_external_fetch_select};
        end
    end

    // ====================================================================
    // Low-time qualification
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            low_cnt   <= 7'h00;
            qualified <= 1'b0;
        end else if (pin_s2) begin
            low_cnt   <= 7'h00;
            qualified <= 1'b0;
        end else if (low_cnt == `RPBS_QUAL_PERIODS - 7'h01) begin
            // Sixty-fourth low cycle qualifies at once
            low_cnt   <= `RPBS_QUAL_PERIODS;  // Saturate
            qualified <= 1'b1;
        end else if (low_cnt != `RPBS_QUAL_PERIODS) begin
            low_cnt   <= low_cnt + 7'h01;
        end
    end

    assign in_reset       = qualified || (state == rpbs_pkg::RPBS_PULL);
    assign o_device_reset = in_reset;
    // Asynchronous port forcing, no clock needed
    assign o_port_force_n = i_reset_pin;
    // Wake from reduced power on pin low
    assign o_wake         = i_low_power && !pin_s2;

    // ====================================================================
    // Internal reset pull-down of the pin
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state    <= rpbs_pkg::RPBS_IDLE;
            pull_cnt <= 4'h0;
        end else begin
            case (state)
                rpbs_pkg::RPBS_IDLE: begin
                    if (i_internal_reset) begin
                        state    <= rpbs_pkg::RPBS_PULL;
                        pull_cnt <= 4'h0;
                    end
                end
                rpbs_pkg::RPBS_PULL: begin
                    if (pull_cnt == `RPBS_PULL_PERIODS - 4'h1 &&
                        !i_internal_reset) begin
                        state <= rpbs_pkg::RPBS_IDLE;
                    end else if (pull_cnt != `RPBS_PULL_PERIODS - 4'h1) begin
                        pull_cnt <= pull_cnt + 4'h1;
                    end
                end
                default: state <= rpbs_pkg::RPBS_IDLE;
            endcase
        end
    end

    assign o_reset_pin_out = 1'b0;
    assign o_reset_pin_oe  = (state == rpbs_pkg::RPBS_PULL);
    assign o_strap_oe      = 1'b0;    // Strap pin is input only

    // ====================================================================
    // Boot strap capture while reset is applied
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_boot <= '0;
        end else if (in_reset) begin
            o_boot.isp_mode   <= !strap_s2;
            o_boot.ext_fetch  <= !fet_s[1];
            o_boot.start_addr <= `RPBS_RESET_VECTOR;
        end
    end

    // ====================================================================
    // Checks

    // Qualification follows exactly 64 counted low cycles
    AST_QUAL_64: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        $rose(qualified) |->
        $past(low_cnt) == `RPBS_QUAL_PERIODS - 7'h01)
        else $error("qualified without 64 low cycles");

    // A qualified pin keeps the device in reset
    AST_QUAL_RST: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        qualified |-> o_device_reset)
        else $error("qualified pin without device reset");

    // Low-time count never runs past the qualifying value
    AST_CNT_MAX: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        low_cnt <= `RPBS_QUAL_PERIODS)
        else $error("low count overran");

    // A high synced pin restarts the count
    AST_RESTART: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        pin_s2 |=> low_cnt == 7'h00 && !qualified)
        else $error("count not restarted on high pin");

    // Port forcing follows a low pin with no clock involved
    AST_PORT: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        !i_reset_pin |-> !o_port_force_n)
        else $error("ports not forced");

    // Ports are released while the pin is high
    AST_PORT_REL: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        i_reset_pin |-> o_port_force_n)
        else $error("ports forced with pin high");

    // Low pin in reduced power wakes the chip
    AST_WAKE: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        i_low_power && !pin_s2 |-> o_wake)
        else $error("no wake on reset pin");

    // No wake outside reduced power
    AST_NO_WAKE: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        !i_low_power |-> !o_wake)
        else $error("wake outside reduced power");

    // Pull lasts at least twelve periods
    AST_PULL12: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        $rose(o_reset_pin_oe) |-> o_reset_pin_oe [*8] ##1
        o_reset_pin_oe [*4])
        else $error("pull shorter than 12 periods");

    // Internal request starts the pull on the next edge
    AST_PULL_START: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        state == rpbs_pkg::RPBS_IDLE && i_internal_reset |=> o_reset_pin_oe)
        else $error("pull not started");

    // Pull stays on while the request stays high
    AST_PULL_HOLD: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        o_reset_pin_oe && i_internal_reset |=> o_reset_pin_oe)
        else $error("pull dropped under request");

    // Driven pin level is low and the device is in reset
    AST_PULL_LOW: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        o_reset_pin_oe |-> !o_reset_pin_out && o_device_reset)
        else $error("pull not low or no reset");

    // Strap pin never driven during reset
    AST_STRAP_IN: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        in_reset |-> !o_strap_oe)
        else $error("strap pin driven in reset");

    // Strap sampled every cycle of reset
    AST_STRAP: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        in_reset |=> o_boot.isp_mode == !$past(strap_s2))
        else $error("strap not sampled");

    // Boot word frozen outside reset
    AST_BOOT_HOLD: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        !in_reset |=> $stable(o_boot))
        else $error("boot word changed outside reset");

    // Fetch select and start address captured in reset
    AST_FETCH: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        in_reset |=> o_boot.ext_fetch == !$past(fet_s[1]) &&
        o_boot.start_addr == `RPBS_RESET_VECTOR)
        else $error("fetch select not applied");

    // Main scenarios
    COV_QUAL: cover property (@(posedge i_mclk) $rose(qualified));
    COV_PULL: cover property (@(posedge i_mclk) $fell(o_reset_pin_oe));
    COV_WAKE: cover property (@(posedge i_mclk) o_wake);
    COV_PULL_LONG: cover property (@(posedge i_mclk)
        o_reset_pin_oe && i_internal_reset &&
        pull_cnt == `RPBS_PULL_PERIODS - 4'h1);
    COV_ISP: cover property (@(posedge i_mclk) $rose(o_boot.isp_mode));
endmodule : rpbs_top
`default_nettype wire

/* File: rtl/rpbs_map.svh */
// Constants for the reset pin and boot strap block
`ifndef RPBS_MAP_SVH
`define RPBS_MAP_SVH
// ========================================================================
// ========================================================================
`define RPBS_QUAL_PERIODS   7'h40
`define RPBS_PULL_PERIODS   4'hC
`define RPBS_RESET_VECTOR   16'h0000
`endif

/* File: rtl/rpbs_pkg.sv */
// Types for the reset pin and boot strap block
`default_nettype none
package rpbs_pkg;
    // Boot configuration captured at reset release
    typedef struct packed {
        logic        isp_mode;
        logic        ext_fetch;
        logic [15:0] start_addr;
    } rpbs_boot_t;

    // Pin pull-down sequencer states
    typedef enum logic [1:0] {
        RPBS_IDLE = 2'b01,
        RPBS_PULL = 2'b10
    } rpbs_state_t;
endpackage : rpbs_pkg
`default_nettype wire

/* File: tb/rpbs_board.sv */
// Board-side reset source model with the pin pull-up
`timescale 1ns/1ns
`default_nettype none
module rpbs_board (
    input  wire logic i_hold_low,
    input  wire logic i_dev_oe,
    input  wire logic i_dev_out,
    output logic      o_pad
);
    // Pad level: the pull-up wins unless a party pulls low
    assign o_pad = (i_hold_low || (i_dev_oe && !i_dev_out)) ? 1'b0 : 1'b1;
endmodule : rpbs_board
`default_nettype wire

/* File: tb/rpbs_top_tb.sv */
// Self-checking bench for the reset pin and boot strap block
`timescale 1ns/1ns
`default_nettype none
module rpbs_top_tb;
    logic i_mclk, i_rst_n, hold, int_rst, low_pw, strap, sel, pad;
    logic pin_out, pin_oe, force_n, dev_rst, wake, s_oe;
    rpbs_pkg::rpbs_boot_t boot;
    integer miscompares = 0, tests_run = 0, seed = 32'h94dab666, n, i;
    rpbs_board board (.i_hold_low(hold), .i_dev_oe(pin_oe),
        .i_dev_out(pin_out), .o_pad(pad));
    rpbs_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reset_pin(pad),
        .i_internal_reset(int_rst), .i_low_power(low_pw),
        .i_program_strobe_strap(strap), .i_external_fetch_select(sel),
        .o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe),
        .o_port_force_n(force_n), .o_device_reset(dev_rst),
        .o_wake(wake), .o_strap_oe(s_oe), .o_boot(boot));
    // ====================================================================
    // Clock, helpers and checks
    initial begin
        i_mclk = 0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic cyc(input integer k);
        repeat (k) @(negedge i_mclk);
    endtask : cyc
    function automatic rpbs_pkg::rpbs_boot_t exp_boot(input logic s, c);
        return {~s, ~c, 16'h0000};
    endfunction : exp_boot
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input rpbs_pkg::rpbs_boot_t got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chkb
    task automatic give_verdict;
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // Watchdog sized well above the expected run
    initial begin
        #(5000 * 100);
        miscompares++;
        give_verdict;
    end
    // ====================================================================
    // Main sequence
    initial begin
        {hold, int_rst, low_pw, i_rst_n} = 4'h0;
        {strap, sel} = 2'h3;
        cyc(2);
        i_rst_n = 1;
        // Short random lows must never qualify
        for (i = 0; i < 8; i++) begin
            n = (i == 0) ? 63 : 1 + {$random(seed)} % 63;
            hold = 1;
            #1 chk(force_n, 1'b0);
            cyc(n);
            hold = 0;
            cyc(4);
            chk(dev_rst, 1'b0);
        end
        // Exactly 64 low periods must qualify
        hold = 1;
        cyc(64);
        hold = 0;
        cyc(2);
        chk(dev_rst, 1'b1);
        cyc(2);
        chk(dev_rst, 1'b0);
        // Long low with random straps
        strap = 1'($random(seed));
        sel = 1'($random(seed));
        hold = 1;
        cyc(60);
        chk(dev_rst, 1'b0);
        low_pw = 1;
        cyc(10);
        chk(dev_rst, 1'b1);
        chk(wake, 1'b1);
        chk(s_oe, 1'b0);
        chkb(boot, exp_boot(strap, sel));
        hold = 0;
        #1 chk(force_n, 1'b1);
        cyc(3);
        chk(wake, 1'b0);
        chk(dev_rst, 1'b0);
        low_pw = 0;
        strap = ~strap;
        cyc(2);
        chkb(boot, exp_boot(~strap, sel));
        // Internal reset pulls the pin for twelve cycles
        int_rst = 1;
        cyc(1);
        int_rst = 0;
        chk(pin_oe, 1'b1);
        chk(pin_out, 1'b0);
        chk(dev_rst, 1'b1);
        cyc(10);
        chk(pin_oe, 1'b1);
        cyc(2);
        chk(pin_oe, 1'b0);
        // Request held past twelve keeps the pull on
        int_rst = 1;
        cyc(15);
        int_rst = 0;
        chk(pin_oe, 1'b1);
        cyc(1);
        chk(pin_oe, 1'b0);
        cyc(5);
        give_verdict;
    end
endmodule : rpbs_top_tb
`default_nettype wire
